// file: design/psc_pkg.sv
/*
   Constants for the pixel sequencer and clamp generator.
   Assumes one 250 MHz clock and an APB slave front end in the top module.
*/
// Notes on behaviour
// - Three-channel gives R,G,B or B,G,R; two-channel alternates the chosen pair.
// - Mono samples one selected colour and outputs it for every pixel.
// - Line mode A repeats two, three or four lines over any sampling mode.
// - Line mode A uses gain/offset of the physical channel processing each pixel.
// - Both line modes attach channel tag bits; extra bits give the line number.
// - Line mode B repeats two, three or four lines.
// - Line mode B uses one common gain/offset set, switched per line colour.
// - Clamp pulse starts a programmed pixel delay after line start, lasts programmed pixels.
// - While clamp is active the input clamp switch ties inputs to the reference.
// - Gated clamp is the AND of the sample phase and the clamp pulse.
// - Each line-start pulse restarts the routing order at the first channel.
package psc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE    = 8'h00;
   localparam logic [7:0] OFS_CLAMP   = 8'h04;
   localparam logic [7:0] OFS_CLDELAY = 8'h08;
   localparam logic [7:0] OFS_CLWIDTH = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   // Mode register fields
   localparam int MODE_SMP_LSB  = 0;  // [1:0] sampling mode
   localparam int MODE_REV_BIT  = 2;  // reverse order
   localparam int MODE_PAIR_LSB = 3;  // [4:3] pair select
   localparam int MODE_MONO_LSB = 5;  // [6:5] mono colour
   localparam int MODE_LSQ_LSB  = 7;  // [8:7] line sequence mode
   localparam int MODE_LEN_LSB  = 9;  // [10:9] lines in sequence minus one
   localparam int MODE_LCOL_LSB = 11; // [18:11] colour of line 0..3, 2 bits each
   // Clamp register fields
   localparam int CLP_EN_BIT    = 0;
   localparam int CLP_GATE_BIT  = 1;
   localparam int CLP_REFEN_BIT = 2;
   // Reset values
   localparam logic [31:0] RST_MODE  = 32'h0001_B000; // Line colour codes 2,1,3,0; mode off
   localparam logic [31:0] RST_CLAMP = 32'h0000_0005; // enabled, internal reference on
   localparam logic [15:0] RST_CLDELAY = 16'h0000;
   localparam logic [15:0] RST_CLWIDTH = 16'h0010;
   // Sampling modes
   typedef enum logic [1:0] {
      PSC_SMP_MONO  = 2'h0,
      PSC_SMP_TWO   = 2'h1,
      PSC_SMP_THREE = 2'h2
   } psc_smp_t;
   // Line sequence modes
   typedef enum logic [1:0] {
      PSC_LSQ_OFF = 2'h0,
      PSC_LSQ_A   = 2'h1,
      PSC_LSQ_B   = 2'h2
   } psc_lsq_t;
   // Colour codes, also channel tag values
   localparam logic [1:0] COL_RED   = 2'h0;
   localparam logic [1:0] COL_GREEN = 2'h1;
   localparam logic [1:0] COL_BLUE  = 2'h2;
   // Clamp states, Gray along wait -> delay -> active
   typedef enum logic [1:0] {
      PSC_CL_IDLE  = 2'h0,
      PSC_CL_DELAY = 2'h1,
      PSC_CL_ON    = 2'h3
   } psc_cl_t;
endpackage

// file: design/psc_pixel_sequencer.sv
/*
   Pixel sequencer and auto-clamp generator, APB registers.
   Assumes lineStart, samplePhase and pixTick synchronous to clk; pixTick marks one
   converter slot, so a pixel period is one slot per channel of the sampling mode.
*/
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module psc_pixel_sequencer #(
   parameter int CNT_W = 16
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        lineStart,
   input  wire logic        pixTick,
   input  wire logic        samplePhase,
   output logic             pixValid,
   output logic [1:0]       muxSel,
   output logic [1:0]       gainSel,
   output logic [1:0]       channelTagBits,
   output logic [1:0]       lineTagBits,
   output logic             inputClampPulse,
   output logic             clampSwitch,
   output logic             clampRefEnable
);
   logic [31:0]      modeReg_ff;
   logic [2:0]       clampReg_ff;
   logic [CNT_W-1:0] clDelay_ff;
   logic [CNT_W-1:0] clWidth_ff;
   logic [1:0]       slot_ff;
   logic [1:0]       line_ff;
   logic             lineSeen_ff;
   logic [CNT_W-1:0] clCnt_ff;
   logic [1:0]       nxt_slot;
   logic [1:0]       nxt_line;
   logic [1:0]       chan;
   logic [1:0]       slots;
   logic [1:0]       lineCol;
   logic [1:0]       pairA;
   logic [1:0]       pairB;
   logic             pixEnd;
   logic             apbAcc;
   logic             addrOk;
   psc_pkg::psc_smp_t smpMode;
   psc_pkg::psc_lsq_t lsqMode;
   psc_pkg::psc_cl_t  clState_ff;

   // Field decode
   assign smpMode = psc_pkg::psc_smp_t'(modeReg_ff[psc_pkg::MODE_SMP_LSB +: 2]);
   assign lsqMode = psc_pkg::psc_lsq_t'(modeReg_ff[psc_pkg::MODE_LSQ_LSB +: 2]);
   assign lineCol = modeReg_ff[psc_pkg::MODE_LCOL_LSB + 2*line_ff +: 2];
   assign apbAcc  = psel & penable;
   assign addrOk  = (paddr == psc_pkg::OFS_MODE) | (paddr == psc_pkg::OFS_CLAMP)
                  | (paddr == psc_pkg::OFS_CLDELAY) | (paddr == psc_pkg::OFS_CLWIDTH)
                  | (paddr == psc_pkg::OFS_STATUS);

   // Pair table: 0 = G/B (default), 1 = R/G, 2 = R/B
   always_comb begin
      case (modeReg_ff[psc_pkg::MODE_PAIR_LSB +: 2])
         2'h1: begin
            pairA = psc_pkg::COL_RED;
            pairB = psc_pkg::COL_GREEN;
         end
         2'h2: begin
            pairA = psc_pkg::COL_RED;
            pairB = psc_pkg::COL_BLUE;
         end
         default: begin
            pairA = psc_pkg::COL_GREEN;
            pairB = psc_pkg::COL_BLUE;
         end
      endcase
   end

   // Channel for the current slot
   always_comb begin
      case (smpMode)
         psc_pkg::PSC_SMP_THREE: begin
            slots = 2'h3;
            if (modeReg_ff[psc_pkg::MODE_REV_BIT])
               chan = 2'(psc_pkg::COL_BLUE - slot_ff);
            else
               chan = slot_ff;
         end
         psc_pkg::PSC_SMP_TWO: begin
            slots = 2'h2;
            chan  = ((slot_ff == 2'h0) ^ modeReg_ff[psc_pkg::MODE_REV_BIT]) ? pairA : pairB;
         end
         default: begin
            slots = 2'h1;
            // Line sequential mono follows the line colour, else the fixed mono pick
            chan  = (lsqMode != psc_pkg::PSC_LSQ_OFF) ? lineCol
                  : modeReg_ff[psc_pkg::MODE_MONO_LSB +: 2];
         end
      endcase
   end

   assign pixEnd   = pixTick & (slot_ff == 2'(slots - 2'h1));
   assign nxt_slot = pixEnd ? 2'h0 : 2'(slot_ff + 2'h1);
   assign nxt_line = (line_ff == modeReg_ff[psc_pkg::MODE_LEN_LSB +: 2]) ? 2'h0
                   : 2'(line_ff + 2'h1);

   // Slot counter, restarted by line start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slot_ff <= 2'h0;
      end else if (lineStart) begin
         slot_ff <= 2'h0;
      end else if (pixTick) begin
         slot_ff <= nxt_slot;
      end
   end

   // Line position in the colour sequence; first line start begins at line 0
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_ff     <= 2'h0;
         lineSeen_ff <= 1'b0;
      end else if (lineStart) begin
         lineSeen_ff <= 1'b1;
         if (lsqMode == psc_pkg::PSC_LSQ_OFF || !lineSeen_ff)
            line_ff <= 2'h0;
         else
            line_ff <= nxt_line;
      end
   end

   // Output stream registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pixValid       <= 1'b0;
         muxSel         <= 2'h0;
         gainSel        <= 2'h0;
         channelTagBits <= 2'h0;
         lineTagBits    <= 2'h0;
      end else begin
         pixValid <= pixTick & ~lineStart;
         muxSel   <= chan;
         // Mode B shares one set chosen by the line colour
         gainSel  <= (lsqMode == psc_pkg::PSC_LSQ_B) ? lineCol : chan;
         channelTagBits <= (lsqMode != psc_pkg::PSC_LSQ_OFF) ? chan : 2'h0;
         lineTagBits    <= (lsqMode != psc_pkg::PSC_LSQ_OFF) ? line_ff : 2'h0;
      end
   end

   // Clamp timing in whole pixels, reloaded at line start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clState_ff <= psc_pkg::PSC_CL_IDLE;
         clCnt_ff   <= '0;
      end else if (lineStart) begin
         clCnt_ff <= clDelay_ff;
         if (!clampReg_ff[psc_pkg::CLP_EN_BIT] || clWidth_ff == '0)
            clState_ff <= psc_pkg::PSC_CL_IDLE;
         else if (clDelay_ff == '0) begin
            clState_ff <= psc_pkg::PSC_CL_ON;
            clCnt_ff   <= clWidth_ff;
         end else
            clState_ff <= psc_pkg::PSC_CL_DELAY;
      end else if (pixEnd) begin
         case (clState_ff)
            psc_pkg::PSC_CL_DELAY: begin
               if (clCnt_ff == CNT_W'(1)) begin
                  clState_ff <= psc_pkg::PSC_CL_ON;
                  clCnt_ff   <= clWidth_ff;
               end else
                  clCnt_ff <= CNT_W'(clCnt_ff - CNT_W'(1));
            end
            psc_pkg::PSC_CL_ON: begin
               if (clCnt_ff == CNT_W'(1))
                  clState_ff <= psc_pkg::PSC_CL_IDLE;
               else
                  clCnt_ff <= CNT_W'(clCnt_ff - CNT_W'(1));
            end
            default: clState_ff <= psc_pkg::PSC_CL_IDLE;
         endcase
      end
   end

   // Clamp outputs; gating trims the reset noise peak out of the clamp window
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         inputClampPulse <= 1'b0;
         clampSwitch     <= 1'b0;
         clampRefEnable  <= 1'b1;
      end else begin
         inputClampPulse <= (clState_ff == psc_pkg::PSC_CL_ON);
         if (clampReg_ff[psc_pkg::CLP_GATE_BIT])
            clampSwitch <= (clState_ff == psc_pkg::PSC_CL_ON) & samplePhase;
         else
            clampSwitch <= (clState_ff == psc_pkg::PSC_CL_ON);
         clampRefEnable <= clampReg_ff[psc_pkg::CLP_REFEN_BIT];
      end
   end

   // APB register writes, zero wait state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         modeReg_ff  <= psc_pkg::RST_MODE;
         clampReg_ff <= psc_pkg::RST_CLAMP[2:0];
         clDelay_ff  <= CNT_W'(psc_pkg::RST_CLDELAY);
         clWidth_ff  <= CNT_W'(psc_pkg::RST_CLWIDTH);
      end else if (apbAcc && pwrite) begin
         case (paddr)
            psc_pkg::OFS_MODE:    modeReg_ff  <= {13'h0000, pwdata[18:0]};
            psc_pkg::OFS_CLAMP:   clampReg_ff <= pwdata[2:0];
            psc_pkg::OFS_CLDELAY: clDelay_ff  <= pwdata[CNT_W-1:0];
            psc_pkg::OFS_CLWIDTH: clWidth_ff  <= pwdata[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   // APB answer: ready every access, error on unmapped address
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addrOk;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               psc_pkg::OFS_MODE:    prdata <= modeReg_ff;
               psc_pkg::OFS_CLAMP:   prdata <= {29'h0000_0000, clampReg_ff};
               psc_pkg::OFS_CLDELAY: prdata <= 32'(clDelay_ff);
               psc_pkg::OFS_CLWIDTH: prdata <= 32'(clWidth_ff);
               psc_pkg::OFS_STATUS:  prdata <= {24'h00_0000, clState_ff, line_ff,
                                                 slot_ff, chan};
               default:              prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/psc_seq_asserts.sv
/*
   Port checker for the pixel sequencer and clamp generator.
   Assumes a bind from the testbench top onto the design's own ports.
*/
`timescale 1ns/10ps
`default_nettype none
module psc_seq_asserts (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       lineStart,
   input wire logic       pixTick,
   input wire logic       pixValid,
   input wire logic [1:0] muxSel,
   input wire logic [1:0] lineTagBits,
   input wire logic       inputClampPulse,
   input wire logic       clampSwitch
);
   // Single clock domain, so clock and reset are shared
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Bus answers in the access cycle, for that cycle only
   chk_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   chk_ready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   // Each converter slot yields one valid pulse, a line start wins
   chk_valid_tick: assert property (pixTick && !lineStart |=> pixValid)
      else $error("slot without valid");
   chk_valid_cause: assert property (pixValid |-> $past(pixTick && !lineStart))
      else $error("valid without slot");
   chk_mux_code: assert property (muxSel != 2'h3)
      else $error("illegal channel");
   // Clamp may only start on a line start or a slot end
   chk_clamp_rise: assert property (
      $rose(inputClampPulse) |-> $past(lineStart || pixTick, 2)) else $error("clamp off grid");
   chk_switch_pulse: assert property (clampSwitch |-> inputClampPulse)
      else $error("switch outside pulse");
   cover property (inputClampPulse && !clampSwitch);
   cover property (pslverr);
   cover property (lineTagBits == 2'h3);
endmodule
`default_nettype wire

// file: verification/psc_sensor_model.sv
/*
   Sensor timing model: converter slot ticks and the sample phase.
   Assumes the bench's line-start pulse also restarts this slot timer.
*/
`timescale 1ns/10ps
`default_nettype none
module psc_sensor_model #(
   parameter int SLOT = 4
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic lineStart,
   output logic      pixTick,
   output logic      samplePhase
);
   logic [7:0] slotCnt_ff;
   // Restart with the line so the first slot is never short
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) slotCnt_ff <= 8'h00;
      else if (lineStart || slotCnt_ff == 8'(SLOT - 1)) slotCnt_ff <= 8'h00;
      else slotCnt_ff <= slotCnt_ff + 8'h01;
   end
   // Tick in the last cycle of a slot; signal portion in its second half
   assign pixTick     = rst_b && slotCnt_ff == 8'(SLOT - 1);
   assign samplePhase = slotCnt_ff >= 8'(SLOT / 2);
endmodule
`default_nettype wire

// file: verification/psc_testbench.sv
/*
   Self-checking bench: registers, channel order, line modes, clamp pulse.
   Assumes the sensor timing model and the port checker compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk, rst_b, psel, penable, pwrite, lineStart, pready, pslverr, er;
   logic        pixTick, samplePhase, pixValid, inputClampPulse, clampSwitch, clampRefEnable;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  muxSel, gainSel, channelTagBits, lineTagBits;
   int          miscompares = 0;
   int          nTests = 0;
   // Mode bits, order of up to three slots, period in slots
   logic [14:0] orderTbl [11] = '{15'h293, 15'h61B, 15'h126, 15'h51A, 15'h912, 15'hD06,
                                  15'h1122, 15'h150A, 15'h001, 15'h2005, 15'h4009};
   psc_pixel_sequencer u_psc_pixel_sequencer (
      .clk             (clk),
      .rst_b           (rst_b),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .lineStart       (lineStart),
      .pixTick         (pixTick),
      .samplePhase     (samplePhase),
      .pixValid        (pixValid),
      .muxSel          (muxSel),
      .gainSel         (gainSel),
      .channelTagBits  (channelTagBits),
      .lineTagBits     (lineTagBits),
      .inputClampPulse (inputClampPulse),
      .clampSwitch     (clampSwitch),
      .clampRefEnable  (clampRefEnable)
   );
   psc_sensor_model u_psc_sensor_model (
      .clk         (clk),
      .rst_b       (rst_b),
      .lineStart   (lineStart),
      .pixTick     (pixTick),
      .samplePhase (samplePhase)
   );
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // A wait that ran out ends the run
   task automatic guard(input logic hit);
      if (hit !== 1'b1) begin
         miscompares++;
         summarize();
      end
   endtask
   // Request held until pready is seen, released at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      guard(pready);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic line();
      @(posedge clk);
      lineStart <= 1'b1;
      @(posedge clk);
      lineStart <= 1'b0;
   endtask
   task automatic nextTick();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1;
         i++;
      end while (pixTick !== 1'b1 && i < 40);
      guard(pixTick);
   endtask
   task automatic t_regs();
      apb(1'b0, psc_pkg::OFS_MODE, 32'h0);
      chk(rd, psc_pkg::RST_MODE);
      apb(1'b0, psc_pkg::OFS_CLAMP, 32'h0);
      chk(rd, psc_pkg::RST_CLAMP);
      apb(1'b1, psc_pkg::OFS_CLDELAY, 32'h2);
      apb(1'b1, psc_pkg::OFS_CLWIDTH, 32'h3);
      apb(1'b0, psc_pkg::OFS_CLDELAY, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      chk(32'(er), 32'h1);
   endtask
   // Second line start mid-line must restart the order
   task automatic t_order(input logic [14:0] e);
      int k;
      apb(1'b1, psc_pkg::OFS_MODE, {25'h0, e[14:8]});
      line();
      for (k = 0; k < 6; k++) begin
         if (k == 4) line();
         nextTick();
         chk(32'(muxSel), 32'(e[2 + 2 * (((k < 4) ? k : k - 4) % e[1:0]) +: 2]));
         chk(32'(channelTagBits), 32'h0);
      end
   endtask
   task automatic t_lseq(input logic [1:0] lsq, input logic [1:0] len, input logic [1:0] smp);
      int k;
      logic [1:0] t0, idx, ch;
      apb(1'b1, psc_pkg::OFS_MODE, {13'h0, 8'h24, len, lsq, 5'h00, smp});
      for (k = 0; k < 6; k++) begin
         line();
         nextTick();
         // Earlier lines already seen, so the first line here is index 1
         if (k == 0) t0 = 2'h1;
         idx = 2'((t0 + k) % (len + 1));
         ch = (lsq == psc_pkg::PSC_LSQ_A) ? psc_pkg::COL_RED : idx;
         chk(32'(lineTagBits), 32'(idx));
         chk(32'(channelTagBits), 32'(ch));
         chk(32'(gainSel), 32'(ch));
      end
   endtask
   // Slot ticks before the pulse, pulse and switch cycles over one line
   task automatic t_clamp(input logic [31:0] c, input int expOn, input int expSw);
      int k, nTk, nOn, nSw;
      apb(1'b1, psc_pkg::OFS_CLAMP, c);
      line();
      chk(32'(clampRefEnable), 32'(c[2]));
      nTk = 0;
      nOn = 0;
      nSw = 0;
      for (k = 0; k < 150; k++) begin
         @(posedge clk);
         #1;
         if (inputClampPulse === 1'b1) nOn++;
         if (clampSwitch === 1'b1) nSw++;
         if (nOn == 0 && pixTick === 1'b1) nTk++;
      end
      if (expOn > 0) chk(32'(nTk), 32'h6);
      chk(32'(nOn), 32'(expOn));
      chk(32'(nSw), 32'(expSw));
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lineStart = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      chk(32'(clampRefEnable), 32'h1);
      t_regs();
      foreach (orderTbl[i]) t_order(orderTbl[i]);
      t_lseq(psc_pkg::PSC_LSQ_B, 2'h2, psc_pkg::PSC_SMP_MONO);
      t_lseq(psc_pkg::PSC_LSQ_A, 2'h3, psc_pkg::PSC_SMP_THREE);
      t_clamp(32'h0000_0001, 36, 36);
      t_clamp(32'h0000_0007, 36, 18);
      t_clamp(32'h0000_0004, 0, 0);
      summarize();
   end
endmodule
bind psc_pixel_sequencer psc_seq_asserts u_psc_seq_asserts (
   .clk             (clk),
   .rst_b           (rst_b),
   .psel            (psel),
   .penable         (penable),
   .pready          (pready),
   .pslverr         (pslverr),
   .lineStart       (lineStart),
   .pixTick         (pixTick),
   .pixValid        (pixValid),
   .muxSel          (muxSel),
   .lineTagBits     (lineTagBits),
   .inputClampPulse (inputClampPulse),
   .clampSwitch     (clampSwitch)
);
`default_nettype wire
